// ==== comparator_event_debouncer.v ====
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "comparator_consts.vh"
module comparator_event_debouncer (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        comparator_raw,
	input  wire        t1_overflow,
	input  wire        cpu_idle,
	input  wire        cpu_power_down,
	input  wire [7:0]  interrupt_enable_register,
	output wire        comparator_out,
	output wire        comparator_irq_req,
	output wire        idle_wakeup,
	output wire        analog_pins_digital_disable,
	output wire        comparator_power_on,
	output wire        irq
);
	reg  [7:0] ctrl_reg;
	reg  [1:0] ists_reg;
	reg  [1:0] imask_reg;
	wire       cmp_sync;
	wire       hit;
	wire       pending;
	wire       enable  = ctrl_reg[`BIT_ENABLE];
	wire       idle_op = ctrl_reg[`BIT_IDLE_OP];
	wire       flag    = ctrl_reg[`BIT_FLAG];
	wire       active  = enable & ~cpu_power_down & (~cpu_idle | idle_op); // [R5] [R7]
	wire       wr = psel & penable & pwrite;
	wire       rd_ok = (paddr == `CTRL_STATUS_ADDR) | (paddr == `IRQ_STATUS_ADDR)
		| (paddr == `IRQ_MASK_ADDR) | (paddr == `STATE_ADDR);
	wire       wr_ctrl = wr & (paddr == `CTRL_STATUS_ADDR);
	wire       set_flag = hit & enable; // [R8]
	wire       flag_rise = set_flag & ~flag;

	// Analog result arrives asynchronously; 1 means positive above negative
	sync2 u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (comparator_raw), // [R15]
		.q       (cmp_sync)
	);

	// Disabled comparator reads low so no stale edge can appear later
	wire sample = cmp_sync & active; // [R10]

	event_detect u_detect (
		.pclk        (pclk),
		.presetn     (presetn),
		.run         (active),
		.mode        (ctrl_reg[2:0]),
		.sample      (sample),
		.t1_overflow (t1_overflow),
		.event_hit   (hit),
		.pending     (pending)
	);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rd_ok;
	assign comparator_out = sample; // [R10]
	assign comparator_irq_req = flag & interrupt_enable_register[`BIT_IE_COMP]; // [R9]
	assign idle_wakeup = comparator_irq_req & cpu_idle & idle_op & ~cpu_power_down; // [R6]
	assign analog_pins_digital_disable = enable; // [R11]
	assign comparator_power_on = active;
	assign irq = |(ists_reg & imask_reg);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= `CTRL_RESET;
			ists_reg  <= 2'h0;
			imask_reg <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg[7:6] <= 2'h0;
				ctrl_reg[5]   <= pwdata[5];
				ctrl_reg[3:0] <= pwdata[3:0];
			end
			// Set wins over a software clear in the same cycle
			if (set_flag) begin
				ctrl_reg[`BIT_FLAG] <= 1'b1; // [R8]
			end else if (wr_ctrl) begin
				ctrl_reg[`BIT_FLAG] <= pwdata[`BIT_FLAG];
			end
			if (wr & (paddr == `IRQ_MASK_ADDR)) begin
				imask_reg <= pwdata[1:0];
			end
			ists_reg[0] <= flag_rise | (ists_reg[0]
				& ~(wr & (paddr == `IRQ_STATUS_ADDR) & pwdata[0]));
			ists_reg[1] <= (wr_ctrl & ~pwdata[`BIT_ENABLE] & enable) | (ists_reg[1]
				& ~(wr & (paddr == `IRQ_STATUS_ADDR) & pwdata[1]));
		end
	end

	always @* begin
		case (paddr)
		`CTRL_STATUS_ADDR: prdata = {24'h000000, ctrl_reg};
		`IRQ_STATUS_ADDR:  prdata = {30'h0, ists_reg};
		`IRQ_MASK_ADDR:    prdata = {30'h0, imask_reg};
		`STATE_ADDR:       prdata = {29'h0, active, pending, sample};
		default:           prdata = 32'h00000000;
		endcase
	end
endmodule

// ==== comparator_consts.vh ====
// Operation
// [R1] Sample comparator output every clock and detect the selected mode condition.
// [R2] Debounced modes wait two timer overflows after a transition, then re-sample.
// [R3] Re-sample matching expected level sets the flag; mismatch discards the event.
// [R4] Debounced flag follows the edge by one to two overflow periods.
// [R5] In idle the logic stops unless idle operation enable (bit 5) is set.
// [R6] Idle operation plus enabled interrupt lets a comparator event wake the CPU.
// [R7] Power-down always disables comparator and event logic.
// [R8] Flag bit 4 sets only with enable and condition met; software clears it. Here a software write of 1 also sets it.
// [R9] Interrupt request needs interrupt enable register bit 6.
// [R10] Enable bit 3 cleared forces output low and blocks new events.
// [R11] Enable bit set disables digital inputs of both analog pins.
// [R12] Mode field: low, rise, dbl toggle, dbl rise, fall, toggle, dbl fall, high.
// [R13] Software keeps Timer 1 running with the desired filter overflow period.
// [R14] Software masks interrupt while settling and clears flag before enabling.
// [R15] Output is high when positive input exceeds negative input.
// [R16] Edges compare current and previous sample; levels flag every matching clock.
`ifndef COMPARATOR_CONSTS_VH
`define COMPARATOR_CONSTS_VH
`define CTRL_STATUS_OFFSET 12'h097
`define CTRL_STATUS_ADDR   12'h25C
`define IRQ_STATUS_ADDR    12'h260
`define IRQ_MASK_ADDR      12'h264
`define STATE_ADDR         12'h268
`define CTRL_RESET         8'h00
`define BIT_MODE_LSB       0
`define BIT_ENABLE         3
`define BIT_FLAG           4
`define BIT_IDLE_OP        5
`define BIT_IE_COMP        6
`define MODE_LOW           3'h0
`define MODE_RISE          3'h1
`define MODE_DB_TOGGLE     3'h2
`define MODE_DB_RISE       3'h3
`define MODE_FALL          3'h4
`define MODE_TOGGLE        3'h5
`define MODE_DB_FALL       3'h6
`define MODE_HIGH          3'h7
`define DEBOUNCE_OVERFLOWS 2'h2
`endif

// ==== sync2.v ====
`timescale 1ns/10ps
module sync2 (
	input  wire pclk,
	input  wire presetn,
	input  wire d,
	output reg  q
);
	reg meta_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ==== event_detect.v ====
`timescale 1ns/10ps
`include "comparator_consts.vh"
module event_detect (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       run,
	input  wire [2:0] mode,
	input  wire       sample,
	input  wire       t1_overflow,
	output reg        event_hit,
	output wire       pending
);
	reg       prev_reg;
	reg       wait_reg;
	reg       expect_reg;
	reg [1:0] ovf_reg;
	wire rise = sample & ~prev_reg;
	wire fall = ~sample & prev_reg;
	wire deb  = (mode == `MODE_DB_TOGGLE) | (mode == `MODE_DB_RISE) | (mode == `MODE_DB_FALL);
	reg  trans;
	assign pending = wait_reg;
	always @* begin
		case (mode) // [R12]
		`MODE_DB_TOGGLE: trans = rise | fall;
		`MODE_DB_RISE:   trans = rise;
		`MODE_DB_FALL:   trans = fall;
		default:         trans = 1'b0;
		endcase
	end
	always @* begin
		case (mode) // [R16]
		`MODE_LOW:    event_hit = run & ~sample;
		`MODE_HIGH:   event_hit = run & sample;
		`MODE_RISE:   event_hit = run & rise;
		`MODE_FALL:   event_hit = run & fall;
		`MODE_TOGGLE: event_hit = run & (rise | fall);
		default:      event_hit = run & wait_reg & (ovf_reg == `DEBOUNCE_OVERFLOWS)
				& (sample == expect_reg); // [R3]
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg   <= 1'b0;
			wait_reg   <= 1'b0;
			expect_reg <= 1'b0;
			ovf_reg    <= 2'h0;
		end else if (!run) begin
			// Stopped logic forgets pending debounces
			wait_reg <= 1'b0;
			ovf_reg  <= 2'h0;
			prev_reg <= sample;
		end else begin
			prev_reg <= sample; // [R1]
			if (!deb) begin
				wait_reg <= 1'b0;
			end else if (wait_reg) begin
				if (ovf_reg == `DEBOUNCE_OVERFLOWS) begin
					wait_reg <= 1'b0; // [R3]
					ovf_reg  <= 2'h0;
				end else if (t1_overflow) begin
					ovf_reg <= ovf_reg + 2'h1; // [R2] [R4]
				end
			end else if (trans) begin
				wait_reg   <= 1'b1; // [R2]
				expect_reg <= sample;
				ovf_reg    <= 2'h0;
			end
		end
	end
endmodule

// ==== comparator_event_debouncer_properties.sv ====
`timescale 1ns/10ps
`include "comparator_consts.vh"
module comparator_event_debouncer_properties (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire        pslverr,
	input wire        comparator_raw,
	input wire        cpu_idle,
	input wire        cpu_power_down,
	input wire [7:0]  interrupt_enable_register,
	input wire        comparator_out,
	input wire        comparator_irq_req,
	input wire        idle_wakeup,
	input wire        analog_pins_digital_disable,
	input wire        comparator_power_on
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire mapped = paddr == `CTRL_STATUS_ADDR || paddr == `IRQ_STATUS_ADDR
		|| paddr == `IRQ_MASK_ADDR || paddr == `STATE_ADDR;
	// Two flops of synchroniser must have run before the output is trusted
	sequence s_on3;
		comparator_power_on [*3];
	endsequence
	AST_SLVERR: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no slave error on unmapped address");
	AST_IRQ_GATE: assert property (!interrupt_enable_register[6] |-> !comparator_irq_req)
		else $error("irq request without enable");
	AST_WAKE: assert property (idle_wakeup |-> comparator_irq_req && cpu_idle && !cpu_power_down)
		else $error("wakeup without cause");
	AST_PD: assert property (cpu_power_down |-> !comparator_power_on && !comparator_out)
		else $error("comparator alive in power down");
	AST_PINS: assert property (comparator_power_on |-> analog_pins_digital_disable)
		else $error("digital inputs not disabled");
	AST_OUT_LOW: assert property (!analog_pins_digital_disable |-> !comparator_out)
		else $error("output high while disabled");
	AST_SAMPLE: assert property (s_on3 |-> comparator_out == $past(comparator_raw, 2))
		else $error("output does not follow input");
	AST_STICKY: assert property (comparator_irq_req && !(psel && penable && pwrite)
		|=> comparator_irq_req || !interrupt_enable_register[6])
		else $error("flag cleared by hardware");
endmodule

// ==== comparator_event_debouncer_tb_top.sv ====
`timescale 1ns/10ps
`include "comparator_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module comparator_event_debouncer_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, e;
	logic        comparator_raw = 0, t1_overflow = 0, cpu_idle = 0, cpu_power_down = 0;
	logic [7:0]  interrupt_enable_register = 8'h00;
	wire         pready, pslverr, comparator_out, comparator_irq_req, idle_wakeup, irq;
	wire         analog_pins_digital_disable, comparator_power_on;
	wire  [31:0] prdata;
	int          failures = 0, total_checks = 0, cycles = 0;
	logic [31:0] exp_q[$];
	comparator_event_debouncer comparator_event_debouncer_i (.*);
	initial forever #20 pclk = ~pclk;
	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (psel && penable && pready && !pwrite) begin
			e = exp_q.pop_front();
			`CHK("prdata", e, prdata)
		end
		if (cycles == 6000) begin
			failures++;
			report_and_stop;
		end
	end
	// On reads d is the expected value; the idle edge first avoids double drive
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back(d);
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic ovf;
		repeat (2) begin
			@(posedge pclk) t1_overflow <= 1;
			@(posedge pclk) t1_overflow <= 0;
			repeat (3) @(posedge pclk);
		end
	endtask
	task automatic step(input logic [2:0] m);
		logic v0, v1, i, o, p, f;
		{v0, v1, i, o, p} = 5'($urandom);
		@(posedge pclk);
		comparator_raw <= v0;
		cpu_idle <= i;
		cpu_power_down <= p;
		interrupt_enable_register <= 8'($urandom);
		apb(1, `CTRL_STATUS_ADDR, {26'h0, o, 2'h1, m});
		ovf;
		apb(1, `CTRL_STATUS_ADDR, {26'h0, o, 2'h1, m});
		comparator_raw <= v1;
		repeat (4) @(posedge pclk);
		ovf;
		case (m)
			`MODE_LOW: f = !v0 || !v1;
			`MODE_HIGH: f = v0 || v1;
			`MODE_RISE, `MODE_DB_RISE: f = !v0 && v1;
			`MODE_FALL, `MODE_DB_FALL: f = v0 && !v1;
			default: f = v0 ^ v1;
		endcase
		f = f && !p && (!i || o);
		apb(0, `CTRL_STATUS_ADDR, {26'h0, o, f, 1'b1, m});
		#1 `CHK("irq_req", f && interrupt_enable_register[6], comparator_irq_req)
		`CHK("wakeup", f && interrupt_enable_register[6] && i, idle_wakeup)
		`CHK("cmp_out", v1 && !p && (!i || o), comparator_out)
		`CHK("power_on", !p && (!i || o), comparator_power_on)
		`CHK("pins", 1'b1, analog_pins_digital_disable)
	endtask
	initial begin
		void'($urandom(7));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, `CTRL_STATUS_ADDR, 32'h00000000);
		apb(0, 12'h000, 32'h00000000);
		repeat (2) for (int m = 0; m < 8; m++) step(3'(m));
		@(posedge pclk);
		comparator_raw <= 0;
		cpu_idle <= 0;
		cpu_power_down <= 0;
		apb(1, `IRQ_STATUS_ADDR, 32'h00000003);
		apb(1, `IRQ_MASK_ADDR, 32'h00000001);
		apb(1, `CTRL_STATUS_ADDR, 32'h00000009);
		apb(0, `IRQ_STATUS_ADDR, 32'h00000000);
		comparator_raw <= 1;
		repeat (6) @(posedge pclk);
		#1 `CHK("irq", 1'b1, irq)
		apb(1, `IRQ_MASK_ADDR, 32'h00000000);
		#1 `CHK("irq", 1'b0, irq)
		apb(0, `IRQ_STATUS_ADDR, 32'h00000001);
		apb(1, `IRQ_STATUS_ADDR, 32'h00000001);
		apb(1, `IRQ_MASK_ADDR, 32'h00000001);
		#1 `CHK("irq", 1'b0, irq)
		@(posedge pclk);
		interrupt_enable_register <= 8'h40;
		cpu_idle <= 1;
		apb(1, `CTRL_STATUS_ADDR, 32'h00000039);
		#1 `CHK("wakeup", 1'b1, idle_wakeup)
		@(posedge pclk);
		cpu_power_down <= 1;
		#1 `CHK("power_on", 1'b0, comparator_power_on)
		`CHK("wakeup", 1'b0, idle_wakeup)
		@(posedge pclk);
		cpu_idle <= 0;
		cpu_power_down <= 0;
		apb(1, `CTRL_STATUS_ADDR, 32'h00000007);
		repeat (4) @(posedge pclk);
		#1 `CHK("cmp_out", 1'b0, comparator_out)
		`CHK("pins", 1'b0, analog_pins_digital_disable)
		apb(0, `CTRL_STATUS_ADDR, 32'h00000007);
		apb(0, `IRQ_STATUS_ADDR, 32'h00000002);
		report_and_stop;
	end
endmodule
bind comparator_event_debouncer comparator_event_debouncer_properties
	comparator_event_debouncer_properties_i (.*);
